// file: design/gir_float_store.sv
// Purpose: Duplicated 32-bit float register banks, read as 16-bit halves
// Assumes: Write and read of one half per cycle
// Notes:   Read is combinational; the parent registers it
`default_nettype none
module gir_float_store
  import gir_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_we,
  input  wire logic [OP_AW-1:0] i_waddr,
  input  wire logic [DW-1:0]    i_wdata,
  input  wire logic             i_half_lo,
  input  wire logic             i_bank_b,
  input  wire logic [OP_AW-1:0] i_raddr_a,
  input  wire logic [OP_AW-1:0] i_raddr_b,
  output logic      [DW-1:0]    o_rdata
);
  logic [2*DW-1:0] bank_a [2**OP_AW];
  logic [2*DW-1:0] bank_b [2**OP_AW];
  logic [2*DW-1:0] word;

  // Both banks take the same data so either can feed the bus
  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      if (i_half_lo)
      begin
        bank_a[i_waddr][DW-1:0] <= i_wdata;
        bank_b[i_waddr][DW-1:0] <= i_wdata;
      end
      else
      begin
        bank_a[i_waddr][2*DW-1:DW] <= i_wdata;
        bank_b[i_waddr][2*DW-1:DW] <= i_wdata;
      end
    end
  end

  always_comb
  begin
    word    = i_bank_b ? bank_b[i_raddr_b] : bank_a[i_raddr_a];
    o_rdata = i_half_lo ? word[DW-1:0] : word[2*DW-1:DW];
  end
endmodule
`default_nettype wire

// file: design/gir_pkg.sv
// Purpose: Shared constants and types for the graphics engine register bank
// Assumes: One clock, microcode strobes synchronous to it
// Notes:   Destination and source codes are the microcode field values
`default_nettype none
package gir_pkg;
  localparam int DW          = 16;
  localparam int SHM_AW      = 14;
  localparam int OP_CW       = 12;
  localparam int OP_AW       = 11;
  localparam int SP_AW       = 12;
  localparam int FS_AW       = 21;
  localparam int FS_HI_W     = 5;
  localparam int JUMP_W      = 15;
  localparam int NCNT_W      = 4;
  localparam int FLAG_W      = 8;
  localparam int LED_W       = 4;
  localparam int EXC_W       = 6;
  localparam int CODE_HI     = 15;
  localparam int CODE_LO     = 14;
  localparam int FILL_HI     = 13;
  localparam int FILL_LO     = 12;
  localparam int ONES_W      = 5;
  localparam logic [1:0] CODE_KEEP   = 2'h0;
  localparam logic [1:0] CODE_SET01  = 2'h1;
  localparam logic [1:0] CODE_SET10  = 2'h2;
  localparam logic [1:0] CODE_TOGGLE = 2'h3;
  localparam logic       DIR_T2R     = 1'b0;
  localparam logic       BANK_A      = 1'b0;
  localparam logic       MODE_NORM   = 1'b0;
  localparam logic       FILL_OFF    = 1'b0;
  localparam logic [15:0] PTR_RST    = 16'h0000;
  localparam logic [FS_AW-1:0] FS_RST = 21'h000000;

  typedef enum logic [3:0] {
    TD_NONE  = 4'h0,
    TD_SHMP  = 4'h1,
    TD_OPA   = 4'h2,
    TD_OPB   = 4'h3,
    TD_RES   = 4'h4,
    TD_NREG  = 4'h5,
    TD_IPF1  = 4'h6,
    TD_STLED = 4'h7,
    TD_JUMP  = 4'h8,
    TD_FPS   = 4'h9
  } gir_te_dst_t;

  typedef enum logic [2:0] {
    TS_FPSTAT = 3'h0,
    TS_IPF2   = 3'h1,
    TS_SHM    = 3'h2,
    TS_FPS    = 3'h3,
    TS_ROM    = 3'h4,
    TS_ALU    = 3'h5
  } gir_te_src_t;

  typedef enum logic [2:0] {
    RD_NONE = 3'h0,
    RD_SPP  = 3'h1,
    RD_FSH  = 3'h2,
    RD_FSL  = 3'h3,
    RD_IPF2 = 3'h4
  } gir_re_dst_t;

  // Sign, subnormal input, bad operand, inexact, too small, overflow
  typedef struct packed {
    logic sgn;
    logic den;
    logic inv;
    logic inx;
    logic und;
    logic ovr;
  } gir_exc_t;

  typedef struct packed {
    logic        wr;
    gir_te_dst_t dst;
    logic        rd;
    gir_te_src_t src;
    logic [15:0] wdata;
    logic        half_lo;
  } gir_te_req_t;

  typedef struct packed {
    logic        wr;
    gir_re_dst_t dst;
    logic [15:0] wdata;
  } gir_re_req_t;
endpackage
`default_nettype wire

// file: design/gir_regs.sv
// Purpose: Microcode-addressed internal registers of both engines
// Assumes: Strobes in i_te and i_re are one-cycle, synchronous to i_clk
// Notes:   Reads answer one cycle after the strobe on o_te_rdata
//
// Operation
// - Shared memory pointer: 16-bit up/down counter
// - Operand/result pointers: 12-bit up counters, 11 used
// - Exception status reads inverted, unused bits one
// - Sticky flags high byte, latest flags low
// - Each result refreshes latest, ORs into sticky
// - Reading exception status clears sticky flags
// - Shift count override held in bits 3-0
// - Flag write bits 15-14 steer FIFO direction
// - Transform flags readable by raster engine
// - Inbound flag register: ones, FIFO status, zero, flags
// - FIFO word presence and direction status bits
// - Status flags to host, LEDs lit low
// - Bits 15-14 select float bank, A default
// - Banks written together; B read for diagnostics
// - Bank A uses pointer A, B pointer B
// - Branch target held in bits 14-0
// - Half select: 0 upper, 1 lower half
// - Scratchpad pointer: 16-bit up counter
// - High pointer bits 15-14 set access mode
// - High pointer bits 13-12 control fill
// - 21-bit frame address counts on read/write commands
`default_nettype none
module gir_regs
  import gir_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  input  wire gir_te_req_t       i_te,
  input  wire gir_re_req_t       i_re,
  input  wire logic              i_shm_up,
  input  wire logic              i_shm_dn,
  input  wire logic              i_opa_inc,
  input  wire logic              i_opb_inc,
  input  wire logic              i_res_inc,
  input  wire logic              i_fpu_result,
  input  wire gir_exc_t          i_fpu_exc,
  input  wire logic              i_fifo_has_word,
  input  wire logic [DW-1:0]     i_shm_rdata,
  input  wire logic [DW-1:0]     i_rom_rdata,
  input  wire logic [DW-1:0]     i_alu_rdata,
  input  wire logic              i_sp_inc,
  input  wire logic              i_fs_start_read,
  input  wire logic              i_fs_write,
  output logic      [DW-1:0]     o_te_rdata,
  output logic      [SHM_AW-1:0] o_shm_addr,
  output logic      [OP_AW-1:0]  o_opa_addr,
  output logic      [OP_AW-1:0]  o_opb_addr,
  output logic      [OP_AW-1:0]  o_res_addr,
  output logic      [NCNT_W-1:0] o_shift_count,
  output logic      [JUMP_W-1:0] o_jump_target,
  output logic                   o_fifo_dir,
  output logic      [FLAG_W-1:0] o_re_flags_in,
  output logic      [LED_W-1:0]  o_status_flags,
  output logic      [LED_W-1:0]  o_leds_n,
  output logic                   o_fp_bank_b,
  output logic      [SP_AW-1:0]  o_sp_addr,
  output logic      [FS_AW-1:0]  o_fs_addr,
  output logic                   o_fs_rmw,
  output logic                   o_fs_fill
);
  // Load wins over count, counting resumes from the loaded value
  function automatic logic [15:0] ctr_next(input logic [15:0] q, input logic ld,
                                           input logic [15:0] v, input logic up,
                                           input logic dn);
    if (ld)
      return v;
    if (up)
      return 16'(q + 16'h0001);
    if (dn)
      return 16'(q - 16'h0001);
    return q;
  endfunction
  // Two-bit mode command: keep, code 01 value, code 10 other value, toggle
  function automatic logic mode_next(input logic cur, input logic [1:0] code,
                                     input logic v01);
    unique case (code)
      CODE_KEEP:   return cur;
      CODE_SET01:  return v01;
      CODE_SET10:  return ~v01;
      CODE_TOGGLE: return ~cur;
    endcase
  endfunction
  logic              te_wr;
  logic              re_wr;
  logic              stat_rd;
  logic [DW-1:0]     fps_rdata;
  logic [1:0]        wr_code;
  logic [1:0]        fill_code;
  // Transform-side pointers
  logic [15:0]       shm_q, shm_d;
  logic [15:0]       opa_q, opa_d;
  logic [15:0]       opb_q, opb_d;
  logic [15:0]       res_q, res_d;
  // Transform-side control
  logic [NCNT_W-1:0] ncnt_q, ncnt_d;
  logic [JUMP_W-1:0] jump_q, jump_d;
  logic              dir_q, dir_d;
  logic              bank_q, bank_d;
  logic [FLAG_W-1:0] out_flags_q, out_flags_d;
  logic [FLAG_W-1:0] in_flags_q, in_flags_d;
  logic [LED_W-1:0]  stat_q, stat_d;
  // LEDs lit on zero, fed from the next flags so the pin is a flop
  logic [LED_W-1:0]  leds_n_q;
  // Exception status
  gir_exc_t          cur_q, cur_d;
  gir_exc_t          acc_q, acc_d;
  logic [DW-1:0]     rdata_q, rdata_d;
  // Raster-side pointers and modes
  logic [15:0]       sp_q, sp_d;
  logic [FS_AW-1:0]  fs_q, fs_d;
  logic              rmw_q, rmw_d;
  logic              fill_q, fill_d;
  assign te_wr     = i_te.wr;
  assign re_wr     = i_re.wr;
  assign stat_rd   = i_te.rd && (i_te.src == TS_FPSTAT);
  assign wr_code   = i_te.wdata[CODE_HI:CODE_LO];
  assign fill_code = i_re.wdata[FILL_HI:FILL_LO];
  gir_float_store u_fstore (
    .i_clk     (i_clk),
    .i_we      (te_wr && (i_te.dst == TD_FPS)),
    .i_waddr   (res_q[OP_AW-1:0]),
    .i_wdata   (i_te.wdata),
    .i_half_lo (i_te.half_lo),
    .i_bank_b  (bank_q),
    .i_raddr_a (opa_q[OP_AW-1:0]),
    .i_raddr_b (opb_q[OP_AW-1:0]),
    .o_rdata   (fps_rdata)
  );
  // Pointer counters
  always_comb
  begin
    shm_d = ctr_next(shm_q, te_wr && (i_te.dst == TD_SHMP), i_te.wdata,
                     i_shm_up, i_shm_dn);
    opa_d = ctr_next(opa_q, te_wr && (i_te.dst == TD_OPA),
                     {4'h0, i_te.wdata[OP_CW-1:0]}, i_opa_inc, 1'b0);
    opb_d = ctr_next(opb_q, te_wr && (i_te.dst == TD_OPB),
                     {4'h0, i_te.wdata[OP_CW-1:0]}, i_opb_inc, 1'b0);
    res_d = ctr_next(res_q, te_wr && (i_te.dst == TD_RES),
                     {4'h0, i_te.wdata[OP_CW-1:0]}, i_res_inc, 1'b0);
    opa_d[15:OP_CW] = 4'h0;
    opb_d[15:OP_CW] = 4'h0;
    res_d[15:OP_CW] = 4'h0;
    sp_d  = ctr_next(sp_q, re_wr && (i_re.dst == RD_SPP), i_re.wdata,
                     i_sp_inc, 1'b0);
  end
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      shm_q <= PTR_RST;
      opa_q <= PTR_RST;
      opb_q <= PTR_RST;
      res_q <= PTR_RST;
      sp_q  <= PTR_RST;
    end
    else
    begin
      shm_q <= shm_d;
      opa_q <= opa_d;
      opb_q <= opb_d;
      res_q <= res_d;
      sp_q  <= sp_d;
    end
  end

  // Transform control registers and flag exchange
  always_comb
  begin
    ncnt_d      = ncnt_q;
    jump_d      = jump_q;
    dir_d       = dir_q;
    bank_d      = bank_q;
    out_flags_d = out_flags_q;
    in_flags_d  = in_flags_q;
    stat_d      = stat_q;
    if (te_wr)
    begin
      unique case (i_te.dst)
        TD_NREG:
          ncnt_d = i_te.wdata[NCNT_W-1:0];
        TD_JUMP:
          jump_d = i_te.wdata[JUMP_W-1:0];
        TD_IPF1:
        begin
          dir_d       = mode_next(dir_q, wr_code, DIR_T2R);
          out_flags_d = i_te.wdata[FLAG_W-1:0];
        end
        TD_STLED:
        begin
          bank_d = mode_next(bank_q, wr_code, BANK_A);
          stat_d = i_te.wdata[LED_W-1:0];
        end
        default:
          ncnt_d = ncnt_q;
      endcase
    end
    if (re_wr && (i_re.dst == RD_IPF2))
      in_flags_d = i_re.wdata[FLAG_W-1:0];
  end
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ncnt_q      <= '0;
      jump_q      <= '0;
      dir_q       <= DIR_T2R;
      bank_q      <= BANK_A;
      out_flags_q <= '0;
      in_flags_q  <= '0;
      stat_q      <= '0;
      leds_n_q    <= '1;
    end
    else
    begin
      ncnt_q      <= ncnt_d;
      jump_q      <= jump_d;
      dir_q       <= dir_d;
      bank_q      <= bank_d;
      out_flags_q <= out_flags_d;
      in_flags_q  <= in_flags_d;
      stat_q      <= stat_d;
      leds_n_q    <= ~stat_d;
    end
  end

  // Exception status and transform read port
  always_comb
  begin
    cur_d = cur_q;
    acc_d = stat_rd ? gir_exc_t'('0) : acc_q;
    // A result in the clearing cycle still lands in the sticky flags
    if (i_fpu_result)
    begin
      cur_d = i_fpu_exc;
      acc_d = acc_d | i_fpu_exc;
    end
    rdata_d = rdata_q;
    if (i_te.rd)
    begin
      unique case (i_te.src)
        TS_FPSTAT:
          rdata_d = {~acc_q, 2'h3, ~cur_q, 2'h3};
        TS_IPF2:
          rdata_d = {{ONES_W{1'b1}}, i_fifo_has_word, dir_q,
                     1'b0, in_flags_q};
        TS_SHM:
          rdata_d = i_shm_rdata;
        TS_FPS:
          rdata_d = fps_rdata;
        TS_ROM:
          rdata_d = i_rom_rdata;
        TS_ALU:
          rdata_d = i_alu_rdata;
        default:
          rdata_d = '1;
      endcase
    end
  end
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cur_q   <= '0;
      acc_q   <= '0;
      rdata_q <= '0;
    end
    else
    begin
      cur_q   <= cur_d;
      acc_q   <= acc_d;
      rdata_q <= rdata_d;
    end
  end

  // Frame-store address and modes
  always_comb
  begin
    fs_d   = fs_q;
    rmw_d  = rmw_q;
    fill_d = fill_q;
    if (i_fs_start_read || i_fs_write)
      fs_d = FS_AW'(fs_q + 21'h000001);
    if (re_wr && (i_re.dst == RD_FSL))
      fs_d[15:0] = i_re.wdata;
    if (re_wr && (i_re.dst == RD_FSH))
    begin
      fs_d[FS_AW-1:16] = i_re.wdata[FS_HI_W-1:0];
      rmw_d  = mode_next(rmw_q, i_re.wdata[CODE_HI:CODE_LO], MODE_NORM);
      fill_d = mode_next(fill_q, fill_code, ~FILL_OFF);
    end
  end
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      fs_q   <= FS_RST;
      rmw_q  <= MODE_NORM;
      fill_q <= FILL_OFF;
    end
    else
    begin
      fs_q   <= fs_d;
      rmw_q  <= rmw_d;
      fill_q <= fill_d;
    end
  end

  assign o_te_rdata     = rdata_q;
  assign o_shm_addr     = shm_q[SHM_AW-1:0];
  // Bit 11 is kept in the counter but drives no address line
  assign o_opa_addr     = opa_q[OP_AW-1:0];
  assign o_opb_addr     = opb_q[OP_AW-1:0];
  assign o_res_addr     = res_q[OP_AW-1:0];
  assign o_shift_count  = ncnt_q;
  assign o_jump_target  = jump_q;
  assign o_fifo_dir     = dir_q;
  assign o_re_flags_in  = out_flags_q;
  assign o_status_flags = stat_q;
  assign o_fp_bank_b    = bank_q;
  assign o_sp_addr      = sp_q[SP_AW-1:0];
  assign o_fs_addr      = fs_q;
  assign o_fs_rmw       = rmw_q;
  assign o_fs_fill      = fill_q;
  assign o_leds_n       = leds_n_q;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_fs_count;
    (i_fs_start_read || i_fs_write) && !(re_wr && (i_re.dst inside {RD_FSL, RD_FSH}));
  endsequence
  sequence s_stat_read_quiet;
    stat_rd && !i_fpu_result ##1 !i_fpu_result;
  endsequence
  a_sticky_read_clear: assert property (s_stat_read_quiet |-> acc_q == '0)
    else $error("sticky flags not cleared by read");
  a_sticky_or_in: assert property (i_fpu_result |=> ((acc_q & $past(i_fpu_exc))
    == $past(i_fpu_exc)) && cur_q == $past(i_fpu_exc))
    else $error("result not merged into exception flags");
  a_stat_read_inv: assert property (stat_rd |=> o_te_rdata[15:10] == ~$past(acc_q)
    && o_te_rdata[7:2] == ~$past(cur_q)
    && o_te_rdata[9:8] == 2'h3 && o_te_rdata[1:0] == 2'h3)
    else $error("exception status not inverted");
  a_fifo_dir_toggle: assert property (te_wr && i_te.dst == TD_IPF1
    && wr_code == CODE_TOGGLE |=> o_fifo_dir != $past(o_fifo_dir))
    else $error("FIFO direction did not toggle");
  a_inflag_layout: assert property (i_te.rd && i_te.src == TS_IPF2 |=>
    o_te_rdata[15:11] == 5'h1F && !o_te_rdata[8] && o_te_rdata[9] == $past(o_fifo_dir)
    && o_te_rdata[10] == $past(i_fifo_has_word))
    else $error("inbound flag register layout wrong");
  a_led_follows: assert property (te_wr && i_te.dst == TD_STLED |=>
    o_leds_n == ~$past(i_te.wdata[3:0]) ##1 o_leds_n == ~o_status_flags)
    else $error("LED outputs do not follow status flags");
  a_fs_step: assert property (s_fs_count |=> o_fs_addr == FS_AW'($past(o_fs_addr) + 1))
    else $error("frame address did not step");
  a_load_wins: assert property (te_wr && i_te.dst == TD_OPB && i_opb_inc |=>
    o_opb_addr == $past(i_te.wdata[10:0]) ##1 (!$past(i_opb_inc) || $past(te_wr)
    || o_opb_addr == OP_AW'($past(o_opb_addr) + 1)))
    else $error("pointer load did not beat count");
  a_fill_enable: assert property (re_wr && i_re.dst == RD_FSH
    && fill_code == CODE_SET01 |=> o_fs_fill)
    else $error("fill mode not enabled");
endmodule
`default_nettype wire

// file: tb/gir_far_model.sv
// Purpose: Far-side data sources seen by the register bank
// Assumes: Memory and unit data follow the addresses with no delay
// Notes:   Each source has its own pattern so a swapped source shows
`default_nettype none
module gir_far_model
  import gir_pkg::*;
(
  input  wire logic              i_fifo_req,
  input  wire logic [SHM_AW-1:0] i_shm_addr,
  output logic      [DW-1:0]     o_shm_rdata,
  output logic      [DW-1:0]     o_rom_rdata,
  output logic      [DW-1:0]     o_alu_rdata,
  output logic                   o_fifo_has_word
);
  timeunit 1ns;
  timeprecision 1ps;
  // Address echo with a marker, so a stale pointer is caught
  assign o_shm_rdata     = {2'h2, i_shm_addr};
  assign o_rom_rdata     = 16'hC35A;
  assign o_alu_rdata     = 16'h1E87;
  assign o_fifo_has_word = i_fifo_req;
endmodule
`default_nettype wire

// file: tb/gir_regs_tb.sv
// Purpose: Self-checking bench for the engine register bank
// Assumes: Inputs change at the falling edge, outputs read there too
// Notes:   Mode codes from a table, counters and reads by hand
`default_nettype none
module gir_regs_tb
  import gir_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic        is_re;
    logic [3:0]  dst;
    logic [15:0] w;
    logic [3:0]  exp;
  } gir_tb_row_t;
  logic        i_clk = 1'b0;
  logic        i_nrst = 1'b0;
  gir_te_req_t te = '0;
  gir_re_req_t re = '0;
  logic [7:0]  cnt = 8'h00;
  logic        fpu_res = 1'b0;
  gir_exc_t    fpu_exc = '0;
  logic        fifo_req = 1'b0;
  logic [DW-1:0] shm_d, rom_d, alu_d, te_rd;
  logic        fifo_w;
  logic [SHM_AW-1:0] shm_a;
  logic [OP_AW-1:0]  opa_a, opb_a, res_a;
  logic [NCNT_W-1:0] shift_c;
  logic [JUMP_W-1:0] jump_t;
  logic [FLAG_W-1:0] re_flags;
  logic [LED_W-1:0]  st_flags, leds_n;
  logic        dir, bank_b, read_modify_write_mode, fill;
  logic [SP_AW-1:0]  sp_a;
  logic [FS_AW-1:0]  fs_a;
  int          bad_count = 0;
  int          n_compared = 0;
  int          cycles = 0;
  // Running state {dir, bank, rmw, fill}; codes 00 keep, 01, 10, 11 toggle
  gir_tb_row_t rows [16] = '{
    '{1'b0, 4'h6, 16'h80A5, 4'h8}, '{1'b0, 4'h6, 16'hC000, 4'h0},
    '{1'b0, 4'h6, 16'hC000, 4'h8}, '{1'b0, 4'h6, 16'h0000, 4'h8},
    '{1'b0, 4'h6, 16'h4000, 4'h0}, '{1'b0, 4'h7, 16'h8005, 4'h4},
    '{1'b0, 4'h7, 16'hC000, 4'h0}, '{1'b0, 4'h7, 16'hC000, 4'h4},
    '{1'b0, 4'h7, 16'h4000, 4'h0}, '{1'b1, 4'h2, 16'h8000, 4'h2},
    '{1'b1, 4'h2, 16'hC000, 4'h0}, '{1'b1, 4'h2, 16'h1000, 4'h1},
    '{1'b1, 4'h2, 16'h3000, 4'h0}, '{1'b1, 4'h2, 16'h3000, 4'h1},
    '{1'b1, 4'h2, 16'hA000, 4'h2}, '{1'b1, 4'h2, 16'h4000, 4'h0}};

  always #4 i_clk = ~i_clk;

  gir_regs dut_u (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_te(te), .i_re(re),
    .i_shm_up(cnt[7]), .i_shm_dn(cnt[6]), .i_opa_inc(cnt[5]),
    .i_opb_inc(cnt[4]), .i_res_inc(cnt[3]), .i_fpu_result(fpu_res),
    .i_fpu_exc(fpu_exc), .i_fifo_has_word(fifo_w), .i_shm_rdata(shm_d),
    .i_rom_rdata(rom_d), .i_alu_rdata(alu_d), .i_sp_inc(cnt[2]),
    .i_fs_start_read(cnt[1]), .i_fs_write(cnt[0]), .o_te_rdata(te_rd),
    .o_shm_addr(shm_a), .o_opa_addr(opa_a), .o_opb_addr(opb_a),
    .o_res_addr(res_a), .o_shift_count(shift_c), .o_jump_target(jump_t),
    .o_fifo_dir(dir), .o_re_flags_in(re_flags), .o_status_flags(st_flags),
    .o_leds_n(leds_n), .o_fp_bank_b(bank_b), .o_sp_addr(sp_a),
    .o_fs_addr(fs_a), .o_fs_rmw(read_modify_write_mode), .o_fs_fill(fill));

  gir_far_model far_u (
    .i_fifo_req(fifo_req), .i_shm_addr(shm_a), .o_shm_rdata(shm_d),
    .o_rom_rdata(rom_d), .o_alu_rdata(alu_d), .o_fifo_has_word(fifo_w));

  function automatic gir_te_req_t tw(gir_te_dst_t d, logic [15:0] w, logic h = 1'b0);
    return '{1'b1, d, 1'b0, TS_FPSTAT, w, h};
  endfunction
  function automatic gir_te_req_t tr(gir_te_src_t s, logic h = 1'b0);
    return '{1'b0, TD_NONE, 1'b1, s, 16'h0000, h};
  endfunction
  function automatic gir_re_req_t rw(gir_re_dst_t d, logic [15:0] w);
    return '{1'b1, d, w};
  endfunction

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One cycle of requests; outputs are settled at the closing falling edge
  task automatic cyc(input gir_te_req_t t, input gir_re_req_t r, input logic [7:0] c);
    @(negedge i_clk);
    te = t;
    re = r;
    cnt = c;
    @(negedge i_clk);
    te = '0;
    re = '0;
    cnt = 8'h00;
  endtask

  task automatic fpu(input gir_exc_t e);
    @(negedge i_clk);
    fpu_res = 1'b1;
    fpu_exc = e;
    @(negedge i_clk);
    fpu_res = 1'b0;
  endtask

  task automatic stop_test;
    $display("Compared %0d, errors %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Ceiling well above the roughly 120 cycles the sequence needs
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      stop_test();
    end
  end

  initial
  begin
    repeat (6) @(negedge i_clk);
    i_nrst = 1'b1;
    chk("modes_rst", {dir, bank_b, read_modify_write_mode, fill}, 4'h0);
    chk("leds_rst", leds_n, 4'hF);
    foreach (rows[k])
    begin
      if (rows[k].is_re)
        cyc('0, rw(gir_re_dst_t'(rows[k].dst[2:0]), rows[k].w), 8'h00);
      else
        cyc(tw(gir_te_dst_t'(rows[k].dst), rows[k].w), '0, 8'h00);
      chk("modes", {dir, bank_b, read_modify_write_mode, fill}, rows[k].exp);
    end
    // Exception flags, active low on read, sticky cleared by the read
    fpu(6'b100001);
    fpu(6'b000010);
    cyc(tr(TS_FPSTAT), '0, 8'h00);
    chk("fpstat", te_rd, 16'h73F7);
    cyc(tr(TS_FPSTAT), '0, 8'h00);
    chk("fpstat_clr", te_rd, 16'hFFF7);
    // Result landing with the read: old value out, new flag kept
    @(negedge i_clk);
    te = tr(TS_FPSTAT);
    fpu_res = 1'b1;
    fpu_exc = 6'b010000;
    @(negedge i_clk);
    te = '0;
    fpu_res = 1'b0;
    chk("fpstat_same", te_rd, 16'hFFF7);
    cyc(tr(TS_FPSTAT), '0, 8'h00);
    chk("fpstat_set_wins", te_rd, 16'hBFBF);
    // Flags both ways and FIFO status
    fifo_req = 1'b1;
    cyc('0, rw(RD_IPF2, 16'hFF3C), 8'h00);
    cyc(tr(TS_IPF2), '0, 8'h00);
    chk("ipf2", te_rd, 16'hFC3C);
    fifo_req = 1'b0;
    cyc(tw(TD_IPF1, 16'h805A), '0, 8'h00);
    chk("re_flags", re_flags, 8'h5A);
    cyc(tr(TS_IPF2), '0, 8'h00);
    chk("ipf2_dir", te_rd, 16'hFA3C);
    cyc(tw(TD_STLED, 16'h0005), '0, 8'h00);
    chk("status", {st_flags, leds_n}, 8'h5A);
    cyc(tw(TD_NREG, 16'hFFF9), '0, 8'h00);
    chk("shift", shift_c, 4'h9);
    cyc(tw(TD_JUMP, 16'hFFFF), '0, 8'h00);
    chk("jump", jump_t, 15'h7FFF);
    // Counters at their wrap boundaries, and a load beating a count
    cyc(tw(TD_SHMP, 16'h3FFF), '0, 8'h00);
    cyc('0, '0, 8'h80);
    chk("shm_up", shm_a, 14'h0000);
    cyc('0, '0, 8'h40);
    chk("shm_dn", shm_a, 14'h3FFF);
    cyc(tw(TD_OPA, 16'h07FF), '0, 8'h00);
    cyc('0, '0, 8'h20);
    chk("opa_b11", opa_a, 11'h000);
    cyc(tw(TD_OPB, 16'h0005), '0, 8'h10);
    chk("opb_load", opb_a, 11'h005);
    cyc('0, '0, 8'h10);
    chk("opb_inc", opb_a, 11'h006);
    cyc('0, rw(RD_SPP, 16'h0FFF), 8'h00);
    cyc('0, '0, 8'h04);
    chk("sp", sp_a, 12'h000);
    cyc('0, rw(RD_FSL, 16'hFFFF), 8'h00);
    cyc('0, rw(RD_FSH, 16'h0003), 8'h00);
    chk("fs_load", fs_a, 21'h03FFFF);
    cyc('0, '0, 8'h02);
    chk("fs_rd", fs_a, 21'h040000);
    cyc('0, '0, 8'h01);
    chk("fs_wr", fs_a, 21'h040001);
    // Float store: halves, both banks, pointer per bank
    cyc(tw(TD_RES, 16'h0003), '0, 8'h00);
    cyc(tw(TD_OPA, 16'h0003), '0, 8'h00);
    cyc(tw(TD_OPB, 16'h0003), '0, 8'h00);
    cyc(tw(TD_FPS, 16'h1234), '0, 8'h00);
    cyc(tw(TD_FPS, 16'h5678, 1'b1), '0, 8'h00);
    cyc(tr(TS_FPS), '0, 8'h00);
    chk("fp_hi", te_rd, 16'h1234);
    cyc(tr(TS_FPS, 1'b1), '0, 8'h00);
    chk("fp_lo", te_rd, 16'h5678);
    cyc(tw(TD_OPA, 16'h0007), '0, 8'h00);
    cyc(tw(TD_STLED, 16'h8000), '0, 8'h00);
    cyc(tr(TS_FPS, 1'b1), '0, 8'h00);
    chk("fp_bank_b", te_rd, 16'h5678);
    cyc('0, '0, 8'h08);
    chk("res_inc", res_a, 11'h004);
    // Far-side sources and an unused source code
    cyc(tr(TS_ROM), '0, 8'h00);
    chk("rom", te_rd, 16'hC35A);
    cyc(tr(TS_ALU), '0, 8'h00);
    chk("alu", te_rd, 16'h1E87);
    cyc(tr(TS_SHM), '0, 8'h00);
    chk("shm", te_rd, 16'hBFFF);
    cyc(tr(gir_te_src_t'(3'h7)), '0, 8'h00);
    chk("unused_src", te_rd, 16'hFFFF);
    // Reset in mid-run brings every mode and the frame address back
    @(negedge i_clk);
    i_nrst = 1'b0;
    @(negedge i_clk);
    i_nrst = 1'b1;
    chk("modes_rst2", {dir, bank_b, read_modify_write_mode, fill}, 4'h0);
    chk("fs_rst2", fs_a, 21'h000000);
    stop_test();
  end
endmodule
`default_nettype wire
